// ### logic/supervision_and_power_modes.sv
// Watchdog, oscillator supervisor and power-mode control with an APB slave
`timescale 1ns/10ps
`include "supervisor_defs.svh"

module supervision_and_power_modes (
  input  wire logic        pclk,             // System clock, 50 MHz
  input  wire logic        presetn,          // Async reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB write
  input  wire logic [11:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error on unmapped address
  input  wire logic        instr_step,       // One pulse per CPU instruction
  input  wire logic        periph_irq,       // Any enabled peripheral interrupt
  input  wire logic        main_osc_tick,    // Main oscillator sample, pin
  input  wire logic        rc_osc_tick,      // RC oscillator sample, pin
  input  wire logic        external_irq_zero_pin, // Wake pin, low active
  input  wire logic        can_receive_pin,  // Wake pin, low active
  input  wire logic        ext_reset_n,      // External hardware reset pin
  output logic             int_reset,        // Internal reset to core
  output logic             use_rc_clk,       // Internal clock taken from RC
  output logic             osc_enable,       // Both oscillators enabled
  output logic             cpu_clk_en,       // CPU clock enable
  output logic             per_clk_en,       // Peripheral clock enable
  output logic             wake_irq          // Power-down wake-up interrupt
);

  supervisor_pkg::sup_state_t s_q, s_d;
  supervisor_pkg::sync_t      y1_q, y2_q;
  logic                       main_prev_q, rc_prev_q;

  function automatic logic [4:0] inc5(input logic [4:0] v);
    inc5 = v + 5'h01;
  endfunction

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y1_q        <= '0;
      y2_q        <= '0;
      main_prev_q <= 1'b0;
      rc_prev_q   <= 1'b0;
    end else begin
      y1_q        <= {2'b00, 2'b00, 2'b00, 2'b00, 2'b00} |
                     {1'b0, main_osc_tick, 1'b0, rc_osc_tick, 1'b0, external_irq_zero_pin,
                      1'b0, can_receive_pin, 1'b0, ext_reset_n};
      y2_q        <= y1_q;
      main_prev_q <= y2_q.main[0];
      rc_prev_q   <= y2_q.rc[0];
    end
  end

  logic main_s, rc_s, external_irq_zero_pin_s, rxd_s, xrst_s;
  assign main_s = y2_q.main[0];
  assign rc_s   = y2_q.rc[0];
  assign external_irq_zero_pin_s = y2_q.external_irq_zero_pin_n[0];
  assign rxd_s  = y2_q.rxd[0];
  assign xrst_s = y2_q.ext_rst_n[0];

  logic main_edge, rc_edge;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_edge <= 1'b0;
      rc_edge   <= 1'b0;
    end else begin
      main_edge <= main_s & ~main_prev_q;
      rc_edge   <= rc_s & ~rc_prev_q;
    end
  end

  logic wr, slow_tick, wdt_tick, ext_rst;
  assign wr = psel & penable & pwrite;
  assign ext_rst = ~xrst_s;

  always_comb begin
    s_d = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;

    // Slow-down divides the CPU, peripheral and watchdog clocks by 32
    slow_tick = 1'b1;
    if (s_q.slow) begin
      s_d.slow_div = inc5(s_q.slow_div);
      slow_tick    = (s_q.slow_div == `SLOW_DIV);
    end
    s_d.per_clk_en = slow_tick & ~s_q.pd;
    s_d.cpu_clk_en = slow_tick & ~s_q.pd & ~s_q.idle;

    // Watchdog prescalers: /6 then /2 gives /12, the /16 stage gives /192
    wdt_tick = 1'b0;
    if (s_q.wdt_run && !s_q.idle && !s_q.pd && slow_tick) begin
      s_d.div12 = (s_q.div12 == `DIV6) ? 4'h0 : s_q.div12 + 4'h1;
      if (s_q.div12 == `DIV6) begin
        s_d.div2 = ~s_q.div2;
        if (!s_q.wdt_pre192) begin
          wdt_tick = s_q.div2;
        end else if (s_q.div2) begin
          s_d.div16 = s_q.div16 + 4'h1;
          wdt_tick  = (s_q.div16 == `DIV16);
        end
      end
    end
    if (wdt_tick) begin
      s_d.wdt_cnt = s_q.wdt_cnt + 15'h0001;
    end

    // Arming bits last one instruction only
    if (instr_step) begin
      s_d.refresh_arm = 1'b0;
      s_d.idle_arm    = 1'b0;
      s_d.pd_arm      = 1'b0;
    end

    // APB access, one wait cycle: pready is registered and rises the cycle after penable
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      unique case (paddr)
        `A_CTRL: begin
          if (wr) begin
            s_d.wdt_pre192 = pwdata[`B_WDT_PRE];
            if (pwdata[`B_WDT_REFRESH]) begin
              s_d.refresh_arm = 1'b1;
            end
            if (pwdata[`B_WDT_START]) begin
              s_d.wdt_run = 1'b1;
              if (s_q.refresh_arm) begin
                s_d.wdt_cnt     = {s_q.wdt_rel, 8'h00};
                s_d.refresh_arm = 1'b0;
              end
            end
          end
          s_d.prdata = {24'h0, s_q.wdt_pre192, 5'h0, s_q.wdt_run, s_q.refresh_arm};
        end
        `A_STATUS: begin
          s_d.prdata = {31'h0, s_q.wdt_status};
        end
        `A_WDT_HI: begin
          if (wr) begin
            s_d.wdt_cnt = {pwdata[6:0], s_q.wdt_cnt[7:0]};
          end
          s_d.prdata = {17'h0, s_q.wdt_cnt};
        end
        `A_WDT_REL: begin
          if (wr) begin
            s_d.wdt_rel = pwdata[6:0];
          end
          s_d.prdata = {25'h0, s_q.wdt_rel};
        end
        `A_POWER_CONTROL_REGISTER: begin
          if (wr) begin
            if (pwdata[`B_IDLE_ARM]) begin
              s_d.idle_arm = 1'b1;
            end
            if (pwdata[`B_PD_ARM]) begin
              s_d.pd_arm = 1'b1;
            end
            if (pwdata[`B_IDLE] && s_q.idle_arm) begin
              s_d.idle = 1'b1;
            end
            if (pwdata[`B_PD] && s_q.pd_arm) begin
              s_d.pd     = 1'b1;
              s_d.osc_en = 1'b0;
            end
            s_d.slow = pwdata[`B_SLOW];
          end
          s_d.prdata = {24'h0, 1'b0, s_q.pd, s_q.idle, s_q.slow, 2'b00, s_q.pd_arm, s_q.idle_arm};
        end
        `A_OSC_STAT: begin
          s_d.prdata = {28'h0, s_q.use_rc, s_q.int_reset, s_q.osc};
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // Leaving idle on a peripheral interrupt
    if (s_q.idle && periph_irq) begin
      s_d.idle = 1'b0;
    end

    // Pin wake-up from power-down restarts oscillators
    s_d.wake_irq = 1'b0;
    if (s_q.pd && (!external_irq_zero_pin_s || !rxd_s)) begin
      s_d.pd           = 1'b0;
      s_d.osc_en       = 1'b1;
      s_d.wake_pending = 1'b1;
      s_d.osc          = supervisor_pkg::OSC_FAIL;
      s_d.use_rc       = 1'b1;
      s_d.win_cnt      = '0;
      s_d.main_cnt     = '0;
    end

    // Oscillator supervisor: compare edge counts in an RC-based window
    if (s_q.osc_en) begin
      if (main_edge) begin
        s_d.main_cnt = s_q.main_cnt + 9'h001;
      end
      if (rc_edge) begin
        s_d.win_cnt = s_q.win_cnt + 8'h01;
      end
      if (rc_edge && s_q.win_cnt == `OSC_WIN) begin
        s_d.main_cnt = '0;
        if (s_q.main_cnt <= {1'b0, `OSC_WIN}) begin
          s_d.osc       = supervisor_pkg::OSC_FAIL;
          s_d.use_rc    = 1'b1;
          s_d.int_reset = 1'b1;
        end else if (s_q.osc == supervisor_pkg::OSC_FAIL) begin
          s_d.osc      = supervisor_pkg::OSC_STAB;
          s_d.use_rc   = 1'b0;
          s_d.stab_cnt = '0;
        end
      end
    end
    if (s_q.osc == supervisor_pkg::OSC_STAB) begin
      s_d.stab_cnt = s_q.stab_cnt + 17'h00001;
      if (s_q.stab_cnt == 17'(`STAB_CYC - 1)) begin
        s_d.osc = supervisor_pkg::OSC_RUN;
        if (s_q.wake_pending) begin
          s_d.wake_irq     = 1'b1;
          s_d.wake_pending = 1'b0;
        end else begin
          s_d.int_reset = 1'b0;
        end
      end
    end

    // Watchdog overflow resets the core
    if (wdt_tick && s_q.wdt_cnt == `WDT_MAX) begin
      s_d.int_reset  = 1'b1;
      s_d.wdt_status = 1'b1;
      s_d.wdt_run    = 1'b0;
      s_d.osc        = supervisor_pkg::OSC_STAB;
      s_d.stab_cnt   = '0;
    end

    // External reset; RAM is not touched here, but the watchdog run, count and status bits and the power-mode register bits are cleared
    if (ext_rst) begin
      s_d.wdt_status  = 1'b0;
      s_d.wdt_run     = 1'b0;
      s_d.wdt_cnt     = '0;
      s_d.idle        = 1'b0;
      s_d.pd          = 1'b0;
      s_d.slow        = 1'b0;
      s_d.osc_en      = 1'b1;
      s_d.idle_arm    = 1'b0;
      s_d.pd_arm      = 1'b0;
      s_d.refresh_arm = 1'b0;
    end
  end

  // Power-on: RC drives the reset logic until main is seen running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.osc       <= supervisor_pkg::OSC_FAIL;
      s_q.use_rc    <= 1'b1;
      s_q.int_reset <= 1'b1;
      s_q.osc_en    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign int_reset  = s_q.int_reset;
  assign use_rc_clk = s_q.use_rc;
  assign osc_enable = s_q.osc_en;
  assign cpu_clk_en = s_q.cpu_clk_en;
  assign per_clk_en = s_q.per_clk_en;
  assign wake_irq   = s_q.wake_irq;

  a_wdt_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.idle || s_q.pd) && !(psel && penable) && !ext_rst |=> $stable(s_q.wdt_cnt))
    else $error("watchdog moved while halted");

  a_wdt_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_tick && s_q.wdt_cnt == `WDT_MAX && !ext_rst |=> int_reset && s_q.wdt_status)
    else $error("overflow gave no reset");

  a_run_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.wdt_run && !ext_rst && !(wdt_tick && s_q.wdt_cnt == `WDT_MAX) |=> s_q.wdt_run)
    else $error("watchdog stopped");

  a_idle_gate: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.idle |=> !cpu_clk_en)
    else $error("cpu clock ran in idle");

  a_pd_osc: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.pd && external_irq_zero_pin_s && rxd_s && !ext_rst |=> !osc_enable)
    else $error("oscillator ran in power down");

  a_slow_div: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.slow && $past(s_q.slow) && per_clk_en |=> !per_clk_en)
    else $error("slow mode did not divide");

  a_fail_reset: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.osc == supervisor_pkg::OSC_FAIL && !s_q.wake_pending |-> int_reset)
    else $error("fail without reset");

  a_refresh_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `A_CTRL && !s_q.pready && pwdata[`B_WDT_START] && s_q.refresh_arm && !ext_rst
      && !(wdt_tick && s_q.wdt_cnt == `WDT_MAX)
    |=> s_q.wdt_cnt[14:8] == $past(s_q.wdt_rel))
    else $error("refresh did not load");

endmodule

// ### logic/supervisor_defs.svh
// Constants for the supervision and power-mode block
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define A_CTRL        12'h000
`define A_STATUS      12'h004
`define A_WDT_HI      12'h008
`define A_WDT_REL     12'h00c
`define A_POWER_CONTROL_REGISTER        12'h010
`define A_OSC_STAT    12'h014

`define B_WDT_REFRESH 0
`define B_WDT_START   1
`define B_WDT_PRE     7
`define B_IDLE_ARM    0
`define B_PD_ARM      1
`define B_SLOW        4
`define B_IDLE        5
`define B_PD          6

`define DIV6          4'h5
`define DIV16         4'hf
`define SLOW_DIV      5'h1f
`define WDT_MAX       15'h7fff
`define CLK_MHZ       50
`define STAB_US       1000
`define STAB_CYC      (`STAB_US * `CLK_MHZ)
`define OSC_WIN       8'hff

`endif

// ### logic/supervisor_pkg.sv
// Types for the supervision and power-mode block
package supervisor_pkg;

  typedef enum logic [1:0] {
    OSC_RUN,
    OSC_FAIL,
    OSC_STAB
  } osc_state_t;

  typedef struct packed {
    logic [14:0] wdt_cnt;
    logic        wdt_run;
    logic [6:0]  wdt_rel;
    logic        wdt_pre192;
    logic        wdt_status;
    logic        refresh_arm;
    logic        idle_arm;
    logic        pd_arm;
    logic        idle;
    logic        pd;
    logic        slow;
    logic [3:0]  div12;
    logic        div2;
    logic [3:0]  div16;
    logic [4:0]  slow_div;
    osc_state_t  osc;
    logic [16:0] stab_cnt;
    logic [7:0]  win_cnt;
    logic [8:0]  main_cnt;
    logic        wake_pending;
    logic        wake_irq;
    logic        int_reset;
    logic        use_rc;
    logic        osc_en;
    logic        cpu_clk_en;
    logic        per_clk_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sup_state_t;

  typedef struct packed {
    logic [1:0] main;
    logic [1:0] rc;
    logic [1:0] external_irq_zero_pin_n;
    logic [1:0] rxd;
    logic [1:0] ext_rst_n;
  } sync_t;

endpackage

// ### tb/osc_model.sv
// Main and RC oscillator samples seen by the supervisor
`timescale 1ns/10ps
module osc_model (
  input  wire logic clk,       // System clock
  input  wire logic run,       // Both oscillators enabled
  input  wire logic fail,      // Main oscillator slowed below RC
  output logic      main_tick, // Main oscillator sample
  output logic      rc_tick    // RC oscillator sample
);
  logic [3:0] main_cnt_q = 4'h0;
  logic [1:0] rc_cnt_q   = 2'h0;
  logic       main_end;
  logic       rc_end;
  initial main_tick = 1'b0;
  initial rc_tick = 1'b0;
  assign main_end = main_cnt_q >= (fail ? 4'hb : 4'h1);
  assign rc_end   = rc_cnt_q >= 2'h2;
  // Both stand still while disabled, and run from time zero otherwise
  always @(posedge clk) begin
    if (!run) begin
      main_tick  <= 1'b0;
      rc_tick    <= 1'b0;
      main_cnt_q <= 4'h0;
      rc_cnt_q   <= 2'h0;
    end else begin
      main_cnt_q <= main_end ? 4'h0 : main_cnt_q + 4'h1;
      rc_cnt_q   <= rc_end ? 2'h0 : rc_cnt_q + 2'h1;
      if (main_end) main_tick <= ~main_tick;
      if (rc_end) rc_tick <= ~rc_tick;
    end
  end
endmodule

// ### tb/supervision_and_power_modes_test.sv
// Self-checking bench for the supervision and power-mode block
`timescale 1ns/10ps
`include "supervisor_defs.svh"
module supervision_and_power_modes_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        instr_step = 0, periph_irq = 0, irq0_n = 1, rx_n = 1, ext_rst_n = 1, fail = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, r1;
  logic        pready, pslverr, e, main_tick, rc_tick;
  logic        int_reset, use_rc_clk, osc_enable, cpu_clk_en, per_clk_en, wake_irq;
  logic [4:0]  outs;
  logic [16:0] lfsr = 17'h13c59;
  logic [6:0]  rel, got7;
  int          mismatches = 0, checks_done = 0, n, ca, cb;

  always #10 pclk = ~pclk;
  assign outs = {use_rc_clk, wake_irq, osc_enable, cpu_clk_en, int_reset};

  supervision_and_power_modes i_supervision_and_power_modes (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_step(instr_step),
    .periph_irq(periph_irq), .main_osc_tick(main_tick), .rc_osc_tick(rc_tick),
    .external_irq_zero_pin(irq0_n), .can_receive_pin(rx_n), .ext_reset_n(ext_rst_n),
    .int_reset(int_reset), .use_rc_clk(use_rc_clk), .osc_enable(osc_enable),
    .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en), .wake_irq(wake_irq));
  osc_model i_osc_model (.clk(pclk), .run(osc_enable), .fail(fail), .main_tick(main_tick), .rc_tick(rc_tick));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k == 64) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task step;
    @(posedge pclk);
    instr_step <= 1'b1;
    @(posedge pclk);
    instr_step <= 1'b0;
  endtask

  task wait_sig(input int w, input logic lvl);
    n = 0;
    while (outs[w] !== lvl && n < 70000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 70000) mismatches++;
  endtask

  task count_en(input int c);
    ca = 0;
    cb = 0;
    repeat (c) begin
      @(posedge pclk);
      ca += (cpu_clk_en === 1'b1);
      cb += (per_clk_en === 1'b1);
    end
  endtask

  // A carry out of the low byte may land between refresh and readback
  task read_hi(input logic [6:0] exp);
    apb(0, `A_WDT_HI, 32'h0);
    got7 = (r[14:8] == exp + 7'h01 && r[7:0] == 8'h00) ? exp : r[14:8];
    chk({25'h0, got7}, {25'h0, exp});
  endtask

  initial begin
    #2800000;
    mismatches++;
    give_verdict;
  end

  initial begin
    cyc(16);
    chk({29'h0, int_reset, use_rc_clk, osc_enable}, 32'h7);
    presetn <= 1'b1;
    wait_sig(0, 1'b0);
    chk(32'(n >= 50000), 32'h1);
    chk({31'h0, use_rc_clk}, 32'h0);
    apb(0, 12'h0fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1, `A_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      rel = {1'b0, lfsr[5:0]};
      apb(1, `A_WDT_REL, {25'h0, rel});
      apb(0, `A_WDT_REL, 32'h0);
      chk(r, {25'h0, rel});
      apb(1, `A_CTRL, 32'h1);
      apb(1, `A_CTRL, 32'h2);
      read_hi(rel);
    end
    apb(1, `A_WDT_REL, {25'h0, rel ^ 7'h10});
    apb(1, `A_CTRL, 32'h1);
    step;
    apb(1, `A_CTRL, 32'h2);
    read_hi(rel);
    apb(1, `A_WDT_HI, 32'hffffff85);
    read_hi(7'h05);
    apb(1, `A_CTRL, 32'h0);
    r1 = r;
    cyc(100);
    apb(0, `A_WDT_HI, 32'h0);
    chk(32'(r[14:0] > r1[14:0]), 32'h1);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h10);
    cyc(4);
    count_en(320);
    chk(32'(ca), 32'h0a);
    chk(32'(cb), 32'h0a);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h0);
    cyc(4);
    count_en(64);
    chk(32'(ca), 32'h40);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h1);
    step;
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h20);
    cyc(3);
    count_en(8);
    chk(32'(ca), 32'h08);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h1);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h20);
    cyc(3);
    apb(0, `A_WDT_HI, 32'h0);
    r1 = r;
    cyc(100);
    apb(0, `A_WDT_HI, 32'h0);
    chk(r, r1);
    count_en(8);
    chk({ca[15:0], cb[15:0]}, 32'h00000008);
    @(posedge pclk);
    periph_irq <= 1'b1;
    wait_sig(1, 1'b1);
    chk(32'(n < 20), 32'h1);
    periph_irq <= 1'b0;
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h2);
    apb(1, `A_POWER_CONTROL_REGISTER, 32'h40);
    cyc(4);
    chk({29'h0, osc_enable, cpu_clk_en, per_clk_en}, 32'h0);
    apb(0, `A_WDT_HI, 32'h0);
    r1 = r;
    cyc(50);
    apb(0, `A_WDT_HI, 32'h0);
    chk(r, r1);
    irq0_n <= 1'b0;
    cyc(4);
    irq0_n <= 1'b1;
    wait_sig(2, 1'b1);
    chk(32'(n < 20), 32'h1);
    wait_sig(3, 1'b1);
    chk(32'(n >= 50000), 32'h1);
    // Slow prescaler: about ten steps in 1920 cycles at /192
    apb(1, `A_CTRL, 32'h82);
    apb(0, `A_WDT_HI, 32'h0);
    r1 = r;
    cyc(1920);
    apb(0, `A_WDT_HI, 32'h0);
    r = {17'h0, 15'(r[14:0] - r1[14:0])};
    chk(32'(r >= 32'h9 && r <= 32'hb), 32'h1);
    apb(1, `A_CTRL, 32'h2);
    apb(1, `A_WDT_HI, 32'h7f);
    wait_sig(0, 1'b1);
    chk(32'(n <= 6200), 32'h1);
    apb(0, `A_STATUS, 32'h0);
    chk({31'h0, r[0]}, 32'h1);
    fail <= 1'b1;
    wait_sig(4, 1'b1);
    chk(32'(n < 4000), 32'h1);
    ext_rst_n <= 1'b0;
    cyc(6);
    ext_rst_n <= 1'b1;
    cyc(4);
    apb(0, `A_STATUS, 32'h0);
    chk({31'h0, r[0]}, 32'h0);
    give_verdict;
  end
endmodule
